// ===== common/fio_regs.vh
// register map, field positions, defaults and timing for the field i/o supervisor
// assumes an apb master with 32-bit data and a 250 MHz clock
//
// Summary of operation
// (RL1) watchdog expiry sets fault, disables every output
// (RL2) host must exchange faster than 20 Hz
// (RL3) output writes ignored while fault is set
// (RL4) fault flag is set out of reset
// (RL5) timeout counts milliseconds, zero disables watchdog
// (RL6) timer uses working timeout, stored kept apart
// (RL7) stored values copied to working at power-up
// (RL8) link rate 2.5 Mbaud unless index stored
// (RL9) rate index 0..11 maps to baud table
// (RL10) shorted output disabled and fault raised
// (RL11) over-temperature disables whole chip, raises fault
// (RL12) each driver chip serves eight outputs
// (RL13) 32 digital inputs, 16 outputs
// (RL14) input threshold 60 percent high, 40 low
// (RL15) analog readings 8 bits, full scale 36.3 V
// (RL16) modes 1 to 3 add analog inputs 0..3
// (RL17) mode 3 encoders on inputs 16..19, 2.5 V
// (RL18) encoders count one per cycle
// (RL19) field voltage reported, loss reported; the voltage reads zero in modes 0 and 1
// (RL20) field voltage outside limits raises fault
// (RL21) mode 0 carries digital bits only
// (RL22) faults sticky until cleared, disabled outputs off
// (RL23) host exchange restarts the watchdog period
`ifndef FIO_REGS_VH
`define FIO_REGS_VH

`define FIO_OFS_CTRL        12'h000
`define FIO_OFS_FAULT       12'h004
`define FIO_OFS_OUTPUT      12'h008
`define FIO_OFS_INPUT       12'h00c
`define FIO_OFS_ANALOG      12'h010
`define FIO_OFS_FIELD_V     12'h014
`define FIO_OFS_ENCODER     12'h018
`define FIO_OFS_WD_WORK     12'h01c
`define FIO_OFS_WD_STORED   12'h020
`define FIO_OFS_RATE_STORED 12'h024
`define FIO_OFS_RATE_WORK   12'h028
`define FIO_OFS_UNIT_STORED 12'h02c
`define FIO_OFS_UNIT_WORK   12'h030
`define FIO_OFS_LIMITS      12'h034

`define FIO_FLT_WD      0
`define FIO_FLT_SHORT   1
`define FIO_FLT_OTEMP   2
`define FIO_FLT_RANGE   3
`define FIO_FLT_LOSS    4
`define FIO_FLT_STARTUP 5
`define FIO_FLT_RESET   6'h20

`define FIO_MODE_IO     2'h0
`define FIO_MODE_AIN    2'h1
`define FIO_MODE_AINFV  2'h2
`define FIO_MODE_ENC    2'h3

`define FIO_NV_SEL_WD   2'h0
`define FIO_NV_SEL_RATE 2'h1
`define FIO_NV_SEL_UNIT 2'h2

`define FIO_WD_DEF_MS   16'h0032
`define FIO_RATE_DEF    4'h9
`define FIO_RATE_MAX    4'hb
`define FIO_ENC_THR     8'h12
`define FIO_FV_LO_DEF   8'h23
`define FIO_FV_HI_DEF   8'he0
`define FIO_CHIP_OUTS   8

`define FIO_CLK_NS      4
`define FIO_MS_NS       1000000
`define FIO_MS_CYCLES   (`FIO_MS_NS / `FIO_CLK_NS)

`endif

// ===== rtl/fio_top.v
// field i/o supervisor: input scan, output control, watchdog, fault latch, parameters
// assumes synchronous field samples, an eeprom image on nv_*_in and an apb master
`timescale 1ns/1ns
`default_nettype none
`include "fio_regs.vh"

module fio_top #(
  parameter integer MS_CYCLES = `FIO_MS_CYCLES,
  parameter integer N_IN      = 32,
  parameter integer N_OUT     = 16
) (
  input  wire            clk,
  input  wire            reset,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire [8*N_IN-1:0] adc_in,
  input  wire [7:0]      field_v_in,
  input  wire            field_loss_in,
  input  wire [N_OUT-1:0] drv_short_in,
  input  wire [1:0]      drv_otw_in,
  input  wire [15:0]     nv_timeout_ms_in,
  input  wire [3:0]      nv_rate_in,
  input  wire [31:0]     nv_unit_in,
  output reg  [N_OUT-1:0] field_out_q,
  output reg  [23:0]     link_baud_q,
  output reg             fault_led_q,
  output reg             nv_wr_q,
  output reg  [1:0]      nv_wr_sel_q,
  output reg  [31:0]     nv_wr_data_q
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function [23:0] rate_baud; // RL9
    input [3:0] idx;
    begin
      case (idx)
        4'h0: rate_baud = 24'd9600;
        4'h1: rate_baud = 24'd19200;
        4'h2: rate_baud = 24'd38400;
        4'h3: rate_baud = 24'd57600;
        4'h4: rate_baud = 24'd115200;
        4'h5: rate_baud = 24'd230400;
        4'h6: rate_baud = 24'd460800;
        4'h7: rate_baud = 24'd921600;
        4'h8: rate_baud = 24'd1250000;
        4'ha: rate_baud = 24'd5000000;
        4'hb: rate_baud = 24'd10000000;
        default: rate_baud = 24'd2500000; // RL8
      endcase
    end
  endfunction

  // schmitt decision: high above hi, low below lo, else hold
  function hyst;
    input       cur;
    input [7:0] v;
    input [7:0] hi;
    input [7:0] lo;
    begin
      if (v > hi)
        hyst = 1'b1;
      else if (v < lo)
        hyst = 1'b0;
      else
        hyst = cur;
    end
  endfunction

  // 1x quadrature step: b low counts up, b high counts down
  function [15:0] enc_next;
    input [15:0] cnt;
    input        dir;
    begin
      if (dir)
        enc_next = cnt - 16'h0001;
      else
        enc_next = cnt + 16'h0001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg  [1:0]       mode_q;
  reg  [5:0]       fault_q;
  reg  [N_OUT-1:0] out_req_q;
  reg  [N_OUT-1:0] short_mask_q;
  reg  [1:0]       chip_mask_q;
  reg  [N_IN-1:0]  din_q;
  reg  [15:0]      wd_work_q;
  reg  [15:0]      wd_stored_q;
  reg  [3:0]       rate_stored_q;
  reg  [3:0]       rate_work_q;
  reg  [31:0]      unit_stored_q;
  reg  [31:0]      unit_work_q;
  reg  [7:0]       fv_lo_q;
  reg  [7:0]       fv_hi_q;
  reg              load_q;
  reg  [31:0]      pre_q;
  reg  [15:0]      ms_q;
  reg  [15:0]      enc0_q;
  reg  [15:0]      enc1_q;
  reg              enc0_a_q;
  reg              enc1_a_q;

  wire             fault_any = |fault_q;
  wire             acc       = psel & penable & pready;
  wire             wr        = acc & pwrite;
  // thresholds at 60 and 40 percent of field supply
  wire [9:0]       fv_x1     = {2'h0, field_v_in};
  wire [9:0]       fv_x2     = {1'h0, field_v_in, 1'h0};
  wire [9:0]       fv_x3     = fv_x2 + fv_x1;
  wire [9:0]       thr_hi    = fv_x3 / 10'd5; // RL14
  wire [9:0]       thr_lo    = fv_x2 / 10'd5; // RL14
  wire             enc_mode  = (mode_q == `FIO_MODE_ENC);
  wire             has_ain   = (mode_q != `FIO_MODE_IO); // RL16 RL21
  wire             has_fv    = (mode_q == `FIO_MODE_AINFV) || enc_mode; // RL19
  wire             exch      = acc && ((paddr == `FIO_OFS_OUTPUT) || (paddr == `FIO_OFS_INPUT));
  wire             wd_fire   = (wd_work_q != 16'h0000) && (ms_q >= wd_work_q); // RL5
  wire             fv_bad    = (field_v_in > fv_hi_q) || (field_v_in < fv_lo_q); // RL20
  wire [N_OUT-1:0] chip_off  = {{`FIO_CHIP_OUTS{chip_mask_q[1]}},
                                {`FIO_CHIP_OUTS{chip_mask_q[0]}}}; // RL12
  wire             clr_flt   = wr && (paddr == `FIO_OFS_FAULT);
  wire             wd_hold   = exch || (wd_work_q == 16'h0000); // RL23 RL5
  wire             ms_tick   = (pre_q == MS_CYCLES - 1);
  wire             enc0_step = enc_mode && din_q[16] && !enc0_a_q; // RL18
  wire             enc1_step = enc_mode && din_q[18] && !enc1_a_q; // RL18
  wire             nv_ok     = wr && !load_q;
  // chip mask kept visible beside the short mask
  wire [31:0]      flt_word  = {6'h00, chip_mask_q, short_mask_q[15:0], 2'h0, fault_q};

  ////////////////////////////////////////////////////////////////////////////
  // input scan with hysteresis; encoder lines use a fixed threshold in mode 3

  reg [N_IN-1:0] din_d;
  integer        i;
  always @* begin
    din_d = din_q;
    for (i = 0; i < N_IN; i = i + 1) begin
      if (enc_mode && i >= 16 && i <= 19)
        din_d[i] = (adc_in[8*i +: 8] >= `FIO_ENC_THR); // RL17
      else
        din_d[i] = hyst(din_q[i], adc_in[8*i +: 8], thr_hi[7:0], thr_lo[7:0]); // RL14
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      din_q    <= {N_IN{1'b0}};
      enc0_q   <= 16'h0000;
      enc1_q   <= 16'h0000;
      enc0_a_q <= 1'b0;
      enc1_a_q <= 1'b0;
    end else begin
      din_q    <= din_d; // RL13
      enc0_a_q <= din_q[16];
      enc1_a_q <= din_q[18];
      // 1x: one count per a rising edge, b sets direction
      if (enc0_step)
        enc0_q <= enc_next(enc0_q, din_q[17]); // RL18
      if (enc1_step)
        enc1_q <= enc_next(enc1_q, din_q[19]); // RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: millisecond prescaler and count

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q <= 32'h0000_0000;
      ms_q  <= 16'h0000;
    end else if (wd_hold) begin // RL23 RL5
      pre_q <= 32'h0000_0000;
      ms_q  <= 16'h0000;
    end else if (ms_tick) begin // RL5
      pre_q <= 32'h0000_0000;
      if (!wd_fire)
        ms_q <= ms_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // faults and output control; a new cause wins over a clear in the same cycle

  reg [5:0] flt_set;
  always @* begin
    flt_set                   = 6'h00;
    flt_set[`FIO_FLT_WD]      = wd_fire; // RL1
    flt_set[`FIO_FLT_SHORT]   = |(drv_short_in & field_out_q); // RL10
    flt_set[`FIO_FLT_OTEMP]   = |drv_otw_in; // RL11
    flt_set[`FIO_FLT_RANGE]   = fv_bad; // RL20
    flt_set[`FIO_FLT_LOSS]    = field_loss_in; // RL19
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_q      <= `FIO_FLT_RESET; // RL4
      out_req_q    <= {N_OUT{1'b0}};
      short_mask_q <= {N_OUT{1'b0}};
      chip_mask_q  <= 2'h0;
      field_out_q  <= {N_OUT{1'b0}};
      fault_led_q  <= 1'b1;
    end else begin
      if (clr_flt)
        fault_q <= (fault_q & ~pwdata[5:0]) | flt_set; // RL22
      else
        fault_q <= fault_q | flt_set; // RL22
      if (clr_flt && pwdata[`FIO_FLT_SHORT])
        short_mask_q <= drv_short_in & field_out_q;
      else
        short_mask_q <= short_mask_q | (drv_short_in & field_out_q); // RL10
      if (clr_flt && pwdata[`FIO_FLT_OTEMP])
        chip_mask_q <= drv_otw_in;
      else
        chip_mask_q <= chip_mask_q | drv_otw_in; // RL11
      if (wd_fire)
        out_req_q <= {N_OUT{1'b0}}; // RL1
      else if (wr && paddr == `FIO_OFS_OUTPUT && !fault_any)
        out_req_q <= pwdata[N_OUT-1:0]; // RL3
      // whole-set shutdown while watchdog or startup fault stands
      if (fault_q[`FIO_FLT_WD] || fault_q[`FIO_FLT_STARTUP])
        field_out_q <= {N_OUT{1'b0}}; // RL1
      else
        field_out_q <= out_req_q & ~short_mask_q & ~chip_off; // RL22 RL12
      fault_led_q <= fault_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameters: stored image and working copies

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      load_q        <= 1'b1;
      mode_q        <= `FIO_MODE_IO;
      wd_work_q     <= `FIO_WD_DEF_MS;
      wd_stored_q   <= `FIO_WD_DEF_MS;
      rate_work_q   <= `FIO_RATE_DEF;
      rate_stored_q <= `FIO_RATE_DEF;
      unit_work_q   <= 32'h0000_0000;
      unit_stored_q <= 32'h0000_0000;
      fv_lo_q       <= `FIO_FV_LO_DEF;
      fv_hi_q       <= `FIO_FV_HI_DEF;
      link_baud_q   <= 24'd2500000;
    end else begin
      link_baud_q <= rate_baud(rate_work_q); // RL8 RL9
      if (load_q) begin
        // first cycle after power-up: image into stored and working
        load_q        <= 1'b0;
        wd_stored_q   <= nv_timeout_ms_in;
        wd_work_q     <= nv_timeout_ms_in; // RL7
        rate_stored_q <= nv_rate_in;
        rate_work_q   <= (nv_rate_in > `FIO_RATE_MAX) ? `FIO_RATE_DEF : nv_rate_in; // RL7 RL8
        unit_stored_q <= nv_unit_in;
        unit_work_q   <= nv_unit_in; // RL7
      end else if (wr) begin
        if (paddr == `FIO_OFS_CTRL) begin
          mode_q <= pwdata[1:0];
        end else if (paddr == `FIO_OFS_WD_WORK) begin
          wd_work_q <= pwdata[15:0]; // RL6
        end else if (paddr == `FIO_OFS_WD_STORED) begin
          // stored only; working value untouched until next power-up
          wd_stored_q  <= pwdata[15:0]; // RL6 RL7
        end else if (paddr == `FIO_OFS_RATE_STORED) begin
          rate_stored_q <= pwdata[3:0]; // RL7
        end else if (paddr == `FIO_OFS_UNIT_STORED) begin
          unit_stored_q <= pwdata; // RL7
        end else if (paddr == `FIO_OFS_UNIT_WORK) begin
          unit_work_q <= pwdata;
        end else if (paddr == `FIO_OFS_LIMITS) begin
          fv_lo_q <= pwdata[7:0];
          fv_hi_q <= pwdata[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored-parameter write port: one strobe per accepted write
  // working copies stay as they are until the next power-up reload

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      nv_wr_q      <= 1'b0;
      nv_wr_sel_q  <= `FIO_NV_SEL_WD;
      nv_wr_data_q <= 32'h0000_0000;
    end else begin
      nv_wr_q <= 1'b0;
      if (nv_ok && paddr == `FIO_OFS_WD_STORED) begin
        nv_wr_q      <= 1'b1; // RL7
        nv_wr_sel_q  <= `FIO_NV_SEL_WD;
        nv_wr_data_q <= {16'h0000, pwdata[15:0]};
      end else if (nv_ok && paddr == `FIO_OFS_RATE_STORED) begin
        nv_wr_q      <= 1'b1; // RL7
        nv_wr_sel_q  <= `FIO_NV_SEL_RATE;
        nv_wr_data_q <= {28'h0000000, pwdata[3:0]};
      end else if (nv_ok && paddr == `FIO_OFS_UNIT_STORED) begin
        nv_wr_q      <= 1'b1; // RL7
        nv_wr_sel_q  <= `FIO_NV_SEL_UNIT;
        nv_wr_data_q <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data latched with pready

  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `FIO_OFS_CTRL)
      rd_d = {30'h0, mode_q};
    else if (paddr == `FIO_OFS_FAULT)
      rd_d = flt_word; // RL22
    else if (paddr == `FIO_OFS_OUTPUT)
      rd_d = {{(32-N_OUT){1'b0}}, out_req_q};
    else if (paddr == `FIO_OFS_INPUT)
      rd_d = din_q; // RL13
    else if (paddr == `FIO_OFS_ANALOG)
      rd_d = has_ain ? adc_in[31:0] : 32'h0000_0000; // RL15 RL16 RL21
    else if (paddr == `FIO_OFS_FIELD_V)
      rd_d = {23'h0, field_loss_in, has_fv ? field_v_in : 8'h00}; // RL19
    else if (paddr == `FIO_OFS_ENCODER)
      rd_d = enc_mode ? {enc1_q, enc0_q} : 32'h0000_0000; // RL17
    else if (paddr == `FIO_OFS_WD_WORK)
      rd_d = {16'h0000, wd_work_q};
    else if (paddr == `FIO_OFS_WD_STORED)
      rd_d = {16'h0000, wd_stored_q};
    else if (paddr == `FIO_OFS_RATE_STORED)
      rd_d = {28'h0000000, rate_stored_q};
    else if (paddr == `FIO_OFS_RATE_WORK)
      rd_d = {rate_work_q, 4'h0, link_baud_q};
    else if (paddr == `FIO_OFS_UNIT_STORED)
      rd_d = unit_stored_q;
    else if (paddr == `FIO_OFS_UNIT_WORK)
      rd_d = unit_work_q;
    else if (paddr == `FIO_OFS_LIMITS)
      rd_d = {16'h0000, fv_hi_q, fv_lo_q};
    else
      err_d = 1'b1;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= err_d;
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== dv/fio_drv_model.sv
// output driver chip model: short shutdown and over-temperature flags
// assumes the bench commands the faults through short_req and otw_req
`timescale 1ns/1ns
`default_nettype none
module fio_drv_model (
  input  wire logic [15:0] field_out_q,
  input  wire logic [15:0] short_req,
  input  wire logic [1:0]  otw_req,
  output logic      [15:0] drv_short_in,
  output logic      [1:0]  drv_otw_in
);
  ////////////////////////////////////////
  // a short only trips while the chip sources that output
  assign drv_short_in = short_req & field_out_q;
  // chip 0 serves outputs 0-7, chip 1 outputs 8-15
  assign drv_otw_in = otw_req;
endmodule
`default_nettype wire

// ===== dv/fio_top_properties.sv
// port assertions for the field i/o supervisor
// assumes one apb wait state and default field voltage limits
`timescale 1ns/1ns
`default_nettype none
module fio_top_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  field_v_in,
  input wire logic        field_loss_in,
  input wire logic [15:0] drv_short_in,
  input wire logic [1:0]  drv_otw_in,
  input wire logic [15:0] field_out_q,
  input wire logic        fault_led_q,
  input wire logic        nv_wr_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic out_ok;
  logic ok1_q;
  logic ok2_q;
  // a fault clear may re-enable outputs held back by masks
  assign out_ok = psel && penable && pready && pwrite
                  && (paddr == 12'h004 || (paddr == 12'h008 && !fault_led_q));
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ok1_q <= 1'h0;
      ok2_q <= 1'h0;
    end else begin
      ok1_q <= out_ok;
      ok2_q <= ok1_q;
    end
  end
  ////////////////////////////////////////
  property p_startup; $fell(reset) |-> fault_led_q; endproperty
  a_startup: assert property (p_startup) else $error("fault clear after reset");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_wait_one; psel && !penable ##1 psel && penable |=> pready; endproperty
  a_wait_one: assert property (p_wait_one) else $error("pready late");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_rise; (field_out_q & ~$past(field_out_q)) != 16'h0 |-> ok1_q || ok2_q; endproperty
  a_rise: assert property (p_rise) else $error("output rose unrequested");
  property p_sticky; $fell(fault_led_q) |-> ok1_q || ok2_q; endproperty
  a_sticky: assert property (p_sticky) else $error("fault cleared itself");
  property p_short;
    $rose(|drv_short_in) |-> ##[1:3] fault_led_q && (field_out_q & drv_short_in) == 16'h0;
  endproperty
  a_short: assert property (p_short) else $error("shorted output kept on");
  property p_otw; drv_otw_in[1] |-> ##[1:3] fault_led_q && field_out_q[15:8] == 8'h00; endproperty
  a_otw: assert property (p_otw) else $error("hot chip kept on");
  property p_range;
    field_v_in < 8'h23 || field_v_in > 8'he0 || field_loss_in |-> ##[1:3] fault_led_q;
  endproperty
  a_range: assert property (p_range) else $error("field voltage fault missed");
  property p_nv; nv_wr_q |=> !nv_wr_q; endproperty
  a_nv: assert property (p_nv) else $error("stored write pulse too long");
  cover property ($rose(|drv_short_in));
  cover property (drv_otw_in[1] ##3 field_out_q[15:8] == 8'h00);
  cover property ($fell(fault_led_q));
endmodule
bind fio_top fio_top_properties u_props (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .field_v_in(field_v_in), .field_loss_in(field_loss_in),
  .drv_short_in(drv_short_in), .drv_otw_in(drv_otw_in), .field_out_q(field_out_q),
  .fault_led_q(fault_led_q), .nv_wr_q(nv_wr_q));
`default_nettype wire

// ===== dv/fio_top_tb.sv
// bench: apb reads checked from a queue, field stimulus, fault scenarios
// assumes fio_top with a 10-cycle millisecond and the driver chip model
`timescale 1ns/1ns
`default_nettype none
`include "fio_regs.vh"
module fio_top_tb;
  logic         clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, nv_wr_data_q, pat, ip, nv_unit = 32'h0;
  logic         pready, pslverr, fault_led_q, nv_wr_q, field_loss_in = 1'h0;
  logic [255:0] adc_in = 256'h0;
  logic [7:0]   field_v_in = 8'h80;
  logic [15:0]  short_req = 16'h0, drv_short_in, field_out_q, nv_to = 16'h0005;
  logic [1:0]   otw_req = 2'h0, drv_otw_in, nv_wr_sel_q;
  logic [3:0]   nv_rate = 4'h0;
  logic [23:0]  link_baud_q;
  logic [32:0]  exp_q[$];
  logic [31:0]  msk_q[$];
  logic [23:0]  rate_tab[12] = '{24'h002580, 24'h004b00, 24'h009600, 24'h00e100,
    24'h01c200, 24'h038400, 24'h070800, 24'h0e1000, 24'h1312d0, 24'h2625a0, 24'h4c4b40,
    24'h989680};
  int           fails = 0, tests_run = 0, cyc = 0, nv_cnt = 0;
  fio_top #(.MS_CYCLES(10)) uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_in(adc_in), .field_v_in(field_v_in), .field_loss_in(field_loss_in),
    .drv_short_in(drv_short_in), .drv_otw_in(drv_otw_in), .nv_timeout_ms_in(nv_to),
    .nv_rate_in(nv_rate), .nv_unit_in(nv_unit), .field_out_q(field_out_q),
    .link_baud_q(link_baud_q), .fault_led_q(fault_led_q), .nv_wr_q(nv_wr_q),
    .nv_wr_sel_q(nv_wr_sel_q), .nv_wr_data_q(nv_wr_data_q));
  fio_drv_model u_drv (.field_out_q(field_out_q), .short_req(short_req), .otw_req(otw_req),
    .drv_short_in(drv_short_in), .drv_otw_in(drv_otw_in));
  always #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_out(input logic [15:0] e);
    chk("field_out_q", {17'h0, e}, {17'h0, field_out_q});
  endtask
  task automatic chk_led(input logic e);
    chk("fault_led_q", {32'h0, e}, {32'h0, fault_led_q});
  endtask
  task automatic rst;
    reset <= 1'h1;
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // request held until pready is sampled, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
    exp_q.push_back({e[32], e[31:0] & m});
    msk_q.push_back(m);
    apb(1'h0, a, 32'h0);
  endtask
  always @(posedge clk)
    if (psel && penable && pready === 1'h1 && !pwrite)
      chk($sformatf("read %h", paddr), exp_q.pop_front(), {pslverr, prdata & msk_q.pop_front()});
  always @(posedge clk) if (nv_wr_q === 1'h1) nv_cnt <= nv_cnt + 1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      results();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(96251));
    nv_unit <= $urandom();
    for (int i = 0; i < 13; i++) begin
      nv_rate <= i[3:0];
      rst();
      chk("link_baud_q", {9'h0, rate_tab[i > 11 ? 9 : i]}, {9'h0, link_baud_q});
    end
    chk_led(1'h1);
    rd(`FIO_OFS_FAULT, 33'h20, 32'h3f);
    rd(`FIO_OFS_UNIT_WORK, {1'h0, nv_unit}, 32'hffffffff);
    wr(`FIO_OFS_WD_STORED, 32'h7);
    repeat (2) @(posedge clk);
    chk("nv_wr_data_q", 33'h7, {1'h0, nv_wr_data_q});
    wr(`FIO_OFS_RATE_STORED, 32'h4);
    repeat (2) @(posedge clk);
    chk("nv_wr_sel_q", 33'h1, {31'h0, nv_wr_sel_q});
    chk("nv_wr_data_q", 33'h4, {1'h0, nv_wr_data_q});
    rd(`FIO_OFS_RATE_WORK, {5'h09, 4'h0, rate_tab[9]}, 32'hffffffff);
    rd(`FIO_OFS_WD_WORK, 33'h5, 32'hffff);
    wr(`FIO_OFS_WD_WORK, 32'h0);
    chk("nv_wr_q pulses", 33'h2, 33'(nv_cnt));
    rd(12'h038, 33'h100000000, 32'h0);
    $display("test power-up done");
    pat = $urandom() | 32'h0108;
    wr(`FIO_OFS_OUTPUT, pat);
    repeat (3) @(posedge clk);
    chk_out(16'h0);
    wr(`FIO_OFS_FAULT, 32'h3f);
    rd(`FIO_OFS_FAULT, 33'h0, 32'h3f);
    wr(`FIO_OFS_OUTPUT, pat);
    repeat (3) @(posedge clk);
    chk_out(pat[15:0]);
    repeat (100) @(posedge clk);
    chk_led(1'h0);
    short_req <= 16'h0008;
    repeat (5) @(posedge clk);
    short_req <= 16'h0;
    chk_out(pat[15:0] & 16'hfff7);
    rd(`FIO_OFS_FAULT, 33'h02, 32'h3f);
    otw_req <= 2'h2;
    repeat (5) @(posedge clk);
    otw_req <= 2'h0;
    chk_out(pat[15:0] & 16'h00f7);
    rd(`FIO_OFS_FAULT, 33'h06, 32'h3f);
    wr(`FIO_OFS_FAULT, 32'h3f);
    repeat (3) @(posedge clk);
    chk_out(pat[15:0]);
    $display("test output faults done");
    for (int k = 0; k < 3; k++) begin
      field_v_in <= k == 0 ? 8'h10 : k == 1 ? 8'hf0 : 8'h80;
      field_loss_in <= k == 2;
      repeat (4) @(posedge clk);
      rd(`FIO_OFS_FAULT, k == 2 ? 33'h10 : 33'h08, 32'h3f);
      field_v_in <= 8'h80;
      field_loss_in <= 1'h0;
      wr(`FIO_OFS_FAULT, 32'h3f);
    end
    $display("test field voltage done");
    ip = $urandom();
    for (int i = 0; i < 32; i++) adc_in[8*i +: 8] <= ip[i] ? 8'hf0 : 8'h10;
    repeat (4) @(posedge clk);
    rd(`FIO_OFS_INPUT, {1'h0, ip}, 32'hffffffff);
    // mid-band level must leave every input where it was
    for (int i = 0; i < 32; i++) adc_in[8*i +: 8] <= 8'h40;
    repeat (4) @(posedge clk);
    rd(`FIO_OFS_INPUT, {1'h0, ip}, 32'hffffffff);
    $display("test inputs done");
    wr(`FIO_OFS_WD_WORK, 32'h2);
    wr(`FIO_OFS_OUTPUT, pat);
    for (int k = 0; k < 8; k++) rd(`FIO_OFS_INPUT, {1'h0, ip}, 32'hffffffff);
    chk_led(1'h0);
    repeat (40) @(posedge clk);
    chk_led(1'h1);
    chk_out(16'h0);
    rd(`FIO_OFS_FAULT, 33'h01, 32'h3f);
    $display("test watchdog done");
    adc_in[31:0] <= $urandom();
    for (int m = 0; m < 4; m++) begin
      wr(`FIO_OFS_CTRL, 32'(m));
      rd(`FIO_OFS_ANALOG, {1'h0, m == 0 ? 32'h0 : adc_in[31:0]}, 32'hffffffff);
      rd(`FIO_OFS_FIELD_V, {25'h0, m >= 2 ? 8'h80 : 8'h00}, 32'hff);
    end
    $display("test modes done");
    // encoder levels sit below the normal threshold on purpose
    adc_in <= {96'h0, 8'h20, 152'h0};
    rst();
    wr(`FIO_OFS_CTRL, 32'h3);
    for (int k = 0; k < 5; k++) begin
      adc_in[8*(k < 3 ? 16 : 18) +: 8] <= 8'h20;
      repeat (3) @(posedge clk);
      adc_in[8*(k < 3 ? 16 : 18) +: 8] <= 8'h00;
      repeat (3) @(posedge clk);
    end
    rd(`FIO_OFS_ENCODER, 33'h0fffe0003, 32'hffffffff);
    $display("test encoders done");
    results();
  end
endmodule
`default_nettype wire
